// file: core/oop_pkg.sv
package oop_pkg;
  localparam int          OOP_NUM_PHYS      = 4;
  localparam int          OOP_NUM_VIRT      = 4;
  localparam int          OOP_CLK_MHZ       = 250;
  localparam int          OOP_RETRY_MS      = 1000;
  localparam int          OOP_RETRY_CYC     = OOP_RETRY_MS * 1000 * OOP_CLK_MHZ;
  localparam int          OOP_TMR_W         = 28;
  // register byte offsets
  localparam logic [5:0]  OOP_ADDR_CTRL     = 6'h00;
  localparam logic [5:0]  OOP_ADDR_CMD      = 6'h04;
  localparam logic [5:0]  OOP_ADDR_STATE    = 6'h08;
  localparam logic [5:0]  OOP_ADDR_IRQ_STAT = 6'h0C;
  localparam logic [5:0]  OOP_ADDR_IRQ_MASK = 6'h10;
  // ctrl fields
  localparam int          OOP_CTRL_LATCH    = 0;
  localparam int          OOP_CTRL_FUSE     = 1;
  // state fields
  localparam int          OOP_ST_FLAG_LSB   = 0;
  localparam int          OOP_ST_RDBK_LSB   = 4;
  localparam int          OOP_ST_LATCH_LSB  = 8;
  localparam int          OOP_ST_VIRT_LSB   = 12;
  localparam logic [1:0]  OOP_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  OOP_RESP_SLVERR   = 2'b10;
  localparam logic [31:0] OOP_RESET_WORD    = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    OOP_RUN     = 2'b00,
    OOP_LATCHED = 2'b01,
    OOP_HOLDOFF = 2'b10
  } oop_state_e;
endpackage

// file: core/oop_protect.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module oop_protect #(
  parameter int unsigned RETRY_CYC = oop_pkg::OOP_RETRY_CYC
)(
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [5:0]                        s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [5:0]                        s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [oop_pkg::OOP_NUM_PHYS-1:0]  overload_sense,
  output logic [oop_pkg::OOP_NUM_PHYS-1:0]       phys_out,
  output logic [oop_pkg::OOP_NUM_VIRT-1:0]       virt_out,
  output logic                                   irq
);
  import oop_pkg::*;

  localparam int NP = OOP_NUM_PHYS;

  // software registers
  logic            overload_latch_enable;
  logic            fuse_clear_request;
  logic            fuse_clear_prev;
  logic [NP-1:0]   cmd_phys;
  logic [OOP_NUM_VIRT-1:0] cmd_virt;
  logic [NP-1:0]   irq_stat;
  logic [NP-1:0]   irq_mask;

  // sense pins are asynchronous to aclk
  logic [NP-1:0]   sense_meta;
  logic [NP-1:0]   sense_sync;

  // per-output state
  logic [NP-1:0]   output_overload_flag;
  logic [NP-1:0]   latched;
  logic [NP-1:0]   ovl_rise;
  logic [NP-1:0]   sense_prev;
  logic            fuse_edge;
  logic [NP-1:0]   next_phys;

  // axi bookkeeping
  logic            aw_held;
  logic            w_held;
  logic [5:0]      aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            do_write;
  logic [31:0]     read_word;
  logic            read_hit;
  logic            wr_hit;

  // two-stage synchroniser; only sense_sync is used downstream
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sense_meta <= '0;
      sense_sync <= '0;
    end
    else
    begin
      sense_meta <= overload_sense;
      sense_sync <= sense_meta;
    end
  end

  // edge detection on the synchronised sense and on the fuse-clear bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sense_prev      <= '0;
      fuse_clear_prev <= 1'b0;
    end
    else
    begin
      sense_prev      <= sense_sync;
      fuse_clear_prev <= fuse_clear_request;
    end
  end

  assign ovl_rise  = sense_sync & ~sense_prev;
  assign fuse_edge = fuse_clear_request & ~fuse_clear_prev;

  // one independent state machine and timer per physical output
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_ch
      oop_state_e           state;
      logic [OOP_TMR_W-1:0] timer;

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          state <= OOP_RUN;
          timer <= '0;
        end
        else
        begin
          case (state)
            OOP_RUN:
            begin
              // latch or retry is chosen at the moment the fault is entered
              if (sense_sync[gi] && overload_latch_enable)
                state <= OOP_LATCHED;
              else if (sense_sync[gi])
              begin
                state <= OOP_HOLDOFF;
                timer <= OOP_TMR_W'(RETRY_CYC - 1);
              end
            end
            OOP_LATCHED:
            begin
              // only a fresh rising edge releases the fuse
              if (fuse_edge)
                state <= OOP_RUN;
            end
            OOP_HOLDOFF:
            begin
              // the pin is already off here, so a fault during the wait changes nothing
              if (timer != '0)
                timer <= timer - 1'b1;
              else
                state <= OOP_RUN; // retry; a persisting fault re-enters
            end
            default: state <= OOP_RUN;
          endcase
        end
      end

      // hold-off counts as protection active, so the state register shows it too
      assign latched[gi] = (state != OOP_RUN);

      // drive only when commanded, no fault sensed and the channel free; a retry
      // with the command withdrawn therefore leaves the pin off
      assign next_phys[gi] = cmd_phys[gi] & ~sense_sync[gi] & ~latched[gi];

      // pin drive: off at once on sense, off while latched or holding off
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          phys_out[gi] <= 1'b0;
        else
          phys_out[gi] <= next_phys[gi];
      end

      // status flag follows the sensed fault
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          output_overload_flag[gi] <= 1'b0;
        else
          output_overload_flag[gi] <= sense_sync[gi];
      end
    end
  endgenerate

  // virtual outputs are untouched by protection
  // they never see the sense pins or the retry timers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      virt_out <= '0;
    else
      virt_out <= cmd_virt;
  end

  // sticky interrupt status; set wins over write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat <= '0;
    else
    begin
      if (do_write && aw_addr == OOP_ADDR_IRQ_STAT && w_strb[0])
        irq_stat <= (irq_stat & ~w_data[NP-1:0]) | ovl_rise;
      else
        irq_stat <= irq_stat | ovl_rise;
    end
  end

  // level interrupt; masking hides an event but never loses it, the status stays set
  assign irq = |(irq_stat & irq_mask);

  // axi write: address and data taken independently
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // write decode; the state register answers okay but keeps its contents
  always_comb
  begin
    case (aw_addr)
      OOP_ADDR_CTRL,
      OOP_ADDR_CMD,
      OOP_ADDR_STATE,
      OOP_ADDR_IRQ_STAT,
      OOP_ADDR_IRQ_MASK: wr_hit = 1'b1;
      default:           wr_hit = 1'b0;
    endcase
  end

  // capture of address and data; each channel stays closed until the pair is used
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // write response; bvalid also closes both channels until it is taken,
  // so only one write is ever in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= OOP_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? OOP_RESP_OKAY : OOP_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // writable registers; state register is read-only and ignores writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overload_latch_enable <= 1'b0;
      fuse_clear_request    <= 1'b0;
      cmd_phys              <= '0;
      cmd_virt              <= '0;
      irq_mask              <= '0;
    end
    else if (do_write && w_strb[0])
    begin
      case (aw_addr)
        OOP_ADDR_CTRL:
        begin
          overload_latch_enable <= w_data[OOP_CTRL_LATCH];
          fuse_clear_request    <= w_data[OOP_CTRL_FUSE];
        end
        OOP_ADDR_CMD:
        begin
          cmd_phys <= w_data[NP-1:0];
          cmd_virt <= w_data[NP+OOP_NUM_VIRT-1:NP];
        end
        OOP_ADDR_IRQ_MASK: irq_mask <= w_data[NP-1:0];
        default: ;
      endcase
    end
  end

  // read mux; readback shows the true pin, so latched outputs read off
  // an unmapped read answers slverr with all-zero data
  always_comb
  begin
    read_word = OOP_RESET_WORD;
    read_hit  = 1'b1;
    case (s_axi_araddr)
      OOP_ADDR_CTRL:
      begin
        read_word[OOP_CTRL_LATCH] = overload_latch_enable;
        read_word[OOP_CTRL_FUSE]  = fuse_clear_request;
      end
      OOP_ADDR_CMD:
        read_word[NP+OOP_NUM_VIRT-1:0] = {cmd_virt, cmd_phys};
      OOP_ADDR_STATE:
      begin
        read_word[OOP_ST_FLAG_LSB +: NP]          = output_overload_flag;
        read_word[OOP_ST_RDBK_LSB +: NP]          = phys_out;
        read_word[OOP_ST_LATCH_LSB +: NP]         = latched;
        read_word[OOP_ST_VIRT_LSB +: OOP_NUM_VIRT] = virt_out;
      end
      OOP_ADDR_IRQ_STAT: read_word[NP-1:0] = irq_stat;
      OOP_ADDR_IRQ_MASK: read_word[NP-1:0] = irq_mask;
      default: read_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= OOP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_word;
      s_axi_rresp  <= read_hit ? OOP_RESP_OKAY : OOP_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // oop_protect
`default_nettype wire

// file: test/oop_load.sv
`timescale 1ns/10ps
`default_nettype none
// load on the physical outputs: a short draws overcurrent only while the driver is on
module oop_load
(
  input  wire logic       aclk,
  input  wire logic [3:0] short_en,
  input  wire logic [3:0] phys_out,
  output logic      [3:0] overload_sense
);
  // sensor lags the driver by a cycle, so every retry of a commanded output shows a brief on pulse
  always_ff @(posedge aclk)
  begin
    overload_sense <= short_en & phys_out;
  end
endmodule // oop_load
`default_nettype wire

// file: test/oop_protect_sva.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the protection block and its register bus
module oop_protect_chk #(
  parameter int unsigned RETRY_CYC = 20
)(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [3:0]  overload_sense,
  input wire logic [3:0]  phys_out,
  input wire logic [3:0]  virt_out,
  input wire logic        irq
);
  import oop_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0]  wcnt;
  logic [31:0] off_cnt [4];
  logic [3:0]  flt;
  // cycles since write data was taken, saturating
  always_ff @(posedge aclk)
  begin
    if (!aresetn) wcnt <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wcnt <= 3'h0;
    else if (wcnt != 3'h7) wcnt <= wcnt + 3'h1;
  end
  sense_off_a: assert property (((overload_sense & $past(overload_sense)
    & $past(overload_sense, 2) & $past(overload_sense, 3) & phys_out) == 4'h0))
    else $error("output on under overload");
  virt_cmd_a: assert property ($changed(virt_out) |-> wcnt <= 3'h4)
    else $error("virtual output moved without a write");
  for (genvar i = 0; i < 4; i++)
  begin : g_off
    // off time of each output, and whether a fault was seen while off
    always_ff @(posedge aclk)
    begin
      off_cnt[i] <= (!aresetn || phys_out[i]) ? 32'h0 : off_cnt[i] + 32'h1;
      flt[i] <= aresetn && !phys_out[i] && (flt[i] || overload_sense[i]);
    end
    retry_gap_a: assert property ($rose(phys_out[i]) && flt[i] |-> off_cnt[i] >= RETRY_CYC - 1)
      else $error("retry came too early");
  end
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  r_retire_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == OOP_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("unmapped read returned data");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  reset_idle_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready && phys_out == 4'h0)
    else $error("not idle after reset");
  cover property ($fell(phys_out[0]));
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == OOP_RESP_SLVERR);
endmodule // oop_protect_chk
`default_nettype wire

// file: test/tb_output_overcurrent_protect.sv
`timescale 1ns/10ps
`default_nettype none
// bench: register traffic plus a shorting load, outputs compared with expectations
module tb_output_overcurrent_protect;
  import oop_pkg::*;
  localparam int RC = 20; // short hold-off keeps the run brief
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rnd = 32'h1480, rv;
  logic [3:0]  short_en = 4'h0, cmd;
  logic [1:0]  rs;
  wire  logic  awready, wready, bvalid, arready, rvalid, irq;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  wire  logic [3:0]  sense, phys, virt;
  int          mismatches = 0, checks_done = 0, cyc = 0, n;
  oop_protect #(.RETRY_CYC(RC)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .overload_sense(sense), .phys_out(phys), .virt_out(virt), .irq(irq));
  oop_load load (.aclk(aclk), .short_en(short_en), .phys_out(phys), .overload_sense(sense));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] exp_phys(input logic [3:0] c, input logic [3:0] blk);
    return c & ~blk;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write: both channels offered, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_p = 1'b1, w_p = 1'b1;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    while (aw_p || w_p)
    begin
      @(posedge aclk);
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
      {awvalid, wvalid} <= {aw_p, w_p};
    end
    while (!bvalid) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask
  // read: rready offered with the address and held until rvalid is sampled
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    {rv, rs} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always #2 aclk = ~aclk;
  // hang guard, well beyond the expected run
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OOP_ADDR_STATE);
    chk(rv, OOP_RESET_WORD);
    wr(OOP_ADDR_IRQ_MASK, 32'hF);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      cmd = rnd[7:4];
      wr(OOP_ADDR_CMD, {24'h0, cmd, 4'hF});
      repeat (4) @(posedge aclk);
      chk(virt, cmd);
    end
    // latch mode: a momentary short keeps output 0 off until the fuse edge
    wr(OOP_ADDR_CTRL, 32'h1);
    short_en <= 4'h1;
    repeat (8) @(posedge aclk);
    short_en <= 4'h0;
    chk(phys, exp_phys(4'hF, 4'h1));
    chk(irq, 1'b1);
    rd(OOP_ADDR_STATE);
    chk(rv, {16'h0, cmd, 12'h1E0});
    rd(OOP_ADDR_IRQ_STAT);
    chk(rv, 32'h1);
    repeat (3 * RC) @(posedge aclk);
    chk(phys, 4'hE);
    wr(OOP_ADDR_CTRL, 32'h3);
    repeat (4) @(posedge aclk);
    chk(phys, 4'hF);
    wr(OOP_ADDR_IRQ_STAT, 32'hF);
    chk(irq, 1'b0);
    // retry mode, masked: output 1 stays shorted through two attempts
    wr(OOP_ADDR_CTRL, 32'h0);
    wr(OOP_ADDR_IRQ_MASK, 32'h0);
    short_en <= 4'h2;
    for (int k = 0; k < 2; k++)
    begin
      do @(posedge aclk); while (phys[1]);
      n = 0;
      do @(posedge aclk); while (!phys[1] && ++n < 100);
      chk(n >= RC && n <= RC + 6, 1'b1);
    end
    chk(irq, 1'b0);
    short_en <= 4'h0;
    repeat (2 * RC + 8) @(posedge aclk);
    chk(phys, 4'hF);
    wr(OOP_ADDR_IRQ_MASK, 32'hF);
    chk(irq, 1'b1);
    wr(OOP_ADDR_IRQ_STAT, 32'hF);
    chk(irq, 1'b0);
    // command withdrawn during hold-off: no retry on output 2
    short_en <= 4'h4;
    repeat (6) @(posedge aclk);
    short_en <= 4'h0;
    wr(OOP_ADDR_CMD, {24'h0, cmd, 4'hB});
    repeat (2 * RC) @(posedge aclk);
    chk(phys, exp_phys(4'hF, 4'h4));
    rd(6'h3C);
    chk(rv, 32'h0);
    chk(rs, OOP_RESP_SLVERR);
    wr(6'h3C, 32'hF);
    chk(rs, OOP_RESP_SLVERR);
    tally_and_finish();
  end
endmodule // tb_output_overcurrent_protect
bind oop_protect oop_protect_chk #(.RETRY_CYC(RETRY_CYC)) chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .overload_sense(overload_sense),
  .phys_out(phys_out), .virt_out(virt_out), .irq(irq));
`default_nettype wire
